// ---- uart_pkg.sv ----
package uart_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFS_TX_CTRL   = 8'h00;
   localparam logic [7:0] OFS_RX_CTRL   = 8'h04;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
   localparam logic [7:0] OFS_DIV_LO    = 8'h0C;
   localparam logic [7:0] OFS_DIV_HI    = 8'h10;
   localparam logic [7:0] OFS_TX_HOLD   = 8'h14;
   localparam logic [7:0] OFS_RX_DATA   = 8'h18;
   localparam logic [7:0] OFS_IRQ_CTRL  = 8'h1C;

   // Transmit control fields
   localparam int TXC_NINE = 6;
   localparam int TXC_EN   = 5;
   localparam int TXC_SYNC = 4;
   localparam int TXC_HIGH_SPEED  = 2;
   localparam int TXC_SHIFT_EMPTY = 1;
   localparam int TXC_D9   = 0;

   // Receive control fields
   localparam int RXC_PORT_EN   = 7;
   localparam int RXC_NINE      = 6;
   localparam int RXC_RECV_EN   = 4;
   localparam int RXC_ADDR_DET  = 3;
   localparam int RXC_FRAME_ERR = 2;
   localparam int RXC_OVERRUN   = 1;
   localparam int RXC_D9    = 0;

   // Baud control fields
   localparam int BC_IDLE  = 6;
   localparam int BC_RXINV = 5;
   localparam int BC_TXINV = 4;
   localparam int BC_WIDE  = 3;

   // Interrupt control fields
   localparam int IC_TXIE = 0;
   localparam int IC_RCIE = 1;
   localparam int IC_PERIPH_EN = 2;
   localparam int IC_GLOBAL_EN = 3;
   localparam int IC_TXIF = 4;
   localparam int IC_RCIF = 5;

   // Writable bits and reset values
   localparam logic [7:0] TXC_WMASK = 8'h75;
   localparam logic [7:0] RXC_WMASK = 8'hD8;
   localparam logic [7:0] BC_WMASK  = 8'h38;
   localparam logic [7:0] IC_WMASK  = 8'h0F;
   localparam logic [7:0] REG_RST   = 8'h00;

   // Oversampling timing in 16x ticks, prescale count, frame bit counts and FIFO depth
   localparam logic [3:0] OVS_LAST   = 4'hF;
   localparam logic [3:0] MAJ_FIRST  = 4'h7;
   localparam logic [3:0] MAJ_SECOND = 4'h8;
   localparam logic [3:0] MAJ_DECIDE = 4'h9;
   localparam logic [1:0] SLOW_PRE   = 2'h3;
   localparam logic [3:0] TX_BITS_8  = 4'hA;
   localparam logic [3:0] TX_BITS_9  = 4'hB;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef struct packed {
      logic       framing_error_flag;
      logic       ninth;
      logic [7:0] data;
   } rx_char_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

endpackage

// ---- rx_fifo.sv ----
`timescale 1ns/1ps
module rx_fifo (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              flush_i,
   // Write and read side
   input  wire logic              push_i,
   input  uart_pkg::rx_char_t     data_i,
   input  wire logic              pop_i,
   output uart_pkg::rx_char_t     head_o,
   output logic [1:0]             count_o
);
   uart_pkg::rx_char_t mem_r [2];
   logic               wr_ptr_r;
   logic               rd_ptr_r;
   logic [1:0]         count_r;
   wire                do_push = push_i && (count_r != uart_pkg::FIFO_DEPTH);
   wire                do_pop  = pop_i && (count_r != 2'h0);

   // Entry storage, one register per slot
   for (genvar i = 0; i < 2; i++) begin : g_slot
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mem_r[i] <= '0;
         end else if (do_push && (wr_ptr_r == 1'(i))) begin
            mem_r[i] <= data_i;
         end
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end else begin
         wr_ptr_r <= wr_ptr_r ^ do_push;
         rd_ptr_r <= rd_ptr_r ^ do_pop;
         count_r  <= count_r + {1'b0, do_push} - {1'b0, do_pop};
      end
   end

   assign head_o  = mem_r[rd_ptr_r];
   assign count_o = count_r;
endmodule

// ---- async_serial_tx_rx.sv ----
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// [RL1] Software sets baud, mode, enable before sending
// [RL2] Transmit enable raises buffer empty flag at once
// [RL3] Enabled transmit interrupt asserts immediately when empty
// [RL4] Nine-bit mode sends ninth bit from field
// [RL5] Software loads ninth bit, then character
// [RL6] Transmit inversion makes idle and data low-true
// [RL7] Receiver runs only when enabled and asynchronous
// [RL8] Recovery at 16x, shifter once per bit
// [RL9] Falling edge starts, mid-start must be low
// [RL10] High mid-start silently abandons the character
// [RL11] Each bit majority-sampled at its centre
// [RL12] Low stop sample sets framing error
// [RL13] Finished character enters FIFO, flags available
// [RL14] FIFO holds two, third in shifter
// [RL15] Data read pops oldest character
// [RL16] After overrun no characters are accepted
// [RL17] Receive inversion resets off, inverts when set
// [RL18] Unimplemented control bits read as zero
// [RL19] Start low, data LSB first, stop high
// [RL20] Queued character loads one cycle after stop
// [RL21] Empty flag clear only busy and queued
// [RL22] Clearing receive or port enable clears overrun
// [RL23] Divisor pair makes shared 16x tick
module async_serial_tx_rx (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Serial pins
   input  wire logic        rx_data_pin_i,
   output logic             tx_clock_pin_o,
   // Interrupt request
   output logic             irq_o
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register bus
   logic [7:0] tx_ctrl_r;
   logic [7:0] rx_ctrl_r;
   logic [7:0] baud_ctrl_r;
   logic [7:0] div_lo_r;
   logic [7:0] div_hi_r;
   logic [7:0] irq_ctrl_r;
   logic       ack_r;
   logic [7:0] rd_nxt;

   // Bus decode
   wire req      = cyc_i && stb_i && !ack_r;
   wire wr       = req && we_i && sel_i[0];
   wire rd       = req && !we_i;
   wire wr_txc   = wr && (adr_i == uart_pkg::OFS_TX_CTRL);
   wire wr_rxc   = wr && (adr_i == uart_pkg::OFS_RX_CTRL);
   wire wr_bc    = wr && (adr_i == uart_pkg::OFS_BAUD_CTRL);
   wire wr_lo    = wr && (adr_i == uart_pkg::OFS_DIV_LO);
   wire wr_hi    = wr && (adr_i == uart_pkg::OFS_DIV_HI);
   wire wr_hold  = wr && (adr_i == uart_pkg::OFS_TX_HOLD);
   wire wr_ic    = wr && (adr_i == uart_pkg::OFS_IRQ_CTRL);
   wire rd_data  = rd && (adr_i == uart_pkg::OFS_RX_DATA);

   // Control fields
   wire port_enable               = rx_ctrl_r[uart_pkg::RXC_PORT_EN];
   wire continuous_receive_enable = rx_ctrl_r[uart_pkg::RXC_RECV_EN];
   wire nine_bit_rx_select        = rx_ctrl_r[uart_pkg::RXC_NINE];
   wire address_detect_enable     = rx_ctrl_r[uart_pkg::RXC_ADDR_DET];
   wire tx_enable                 = tx_ctrl_r[uart_pkg::TXC_EN];
   wire nine_bit_tx_select        = tx_ctrl_r[uart_pkg::TXC_NINE];
   wire tx_ninth_bit              = tx_ctrl_r[uart_pkg::TXC_D9];
   wire sync_mode                 = tx_ctrl_r[uart_pkg::TXC_SYNC];
   wire high_speed_baud_select    = tx_ctrl_r[uart_pkg::TXC_HIGH_SPEED];
   wire wide_baud_divider         = baud_ctrl_r[uart_pkg::BC_WIDE];
   wire tx_invert                 = baud_ctrl_r[uart_pkg::BC_TXINV];
   wire rx_invert                 = baud_ctrl_r[uart_pkg::BC_RXINV];

   // Control registers, masked so unused bits stay zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_ctrl_r   <= uart_pkg::REG_RST;
         rx_ctrl_r   <= uart_pkg::REG_RST;
         baud_ctrl_r <= uart_pkg::REG_RST; // RL17
         div_lo_r    <= uart_pkg::REG_RST;
         div_hi_r    <= uart_pkg::REG_RST;
         irq_ctrl_r  <= uart_pkg::REG_RST;
      end else begin
         if (wr_txc) tx_ctrl_r <= dat_i[7:0] & uart_pkg::TXC_WMASK;
         if (wr_rxc) rx_ctrl_r <= dat_i[7:0] & uart_pkg::RXC_WMASK;
         if (wr_bc) baud_ctrl_r <= dat_i[7:0] & uart_pkg::BC_WMASK;
         if (wr_lo) div_lo_r <= dat_i[7:0];
         if (wr_hi) div_hi_r <= dat_i[7:0];
         if (wr_ic) irq_ctrl_r <= dat_i[7:0] & uart_pkg::IC_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Baud tick generator
   logic [15:0] base_cnt_r;
   logic [1:0]  pre_cnt_r;
   logic        tick_r;
   wire [15:0]  div_eff = wide_baud_divider ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
   wire         base    = (base_cnt_r == 16'h0000);

   // Divisor pair, then x4 prescale when not high speed
   always_ff @(posedge clk_i) begin
      if (rst_i || !port_enable) begin
         base_cnt_r <= 16'h0000;
         pre_cnt_r  <= 2'h0;
         tick_r     <= 1'b0;
      end else begin
         base_cnt_r <= base ? div_eff : base_cnt_r - 16'h0001; // RL23
         if (base) pre_cnt_r <= pre_cnt_r + 2'h1;
         tick_r <= base && (high_speed_baud_select || pre_cnt_r == uart_pkg::SLOW_PRE); // RL23
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Transmitter
   logic [8:0]  hold_r;
   logic        hold_full_r;
   logic [10:0] tx_shift_reg;
   logic [3:0]  tx_bits_r;
   logic [3:0]  tx_cnt_r;
   logic        tx_busy_r;
   logic        tx_pin_r;
   wire         tx_on   = tx_enable && port_enable;
   wire         tx_load = hold_full_r && !tx_busy_r && tx_on; // RL20
   wire         tx_step = tx_busy_r && tick_r && (tx_cnt_r == uart_pkg::OVS_LAST);
   wire         tx_done = tx_step && (tx_bits_r == 4'h1);
   wire         tx_buffer_empty_flag = tx_enable && !(hold_full_r && tx_busy_r); // RL2 RL21
   wire         tx_shifter_empty     = !tx_busy_r; // RL21

   // Holding register; a new write wins over the load clear
   always_ff @(posedge clk_i) begin
      if (rst_i || !tx_on) begin
         hold_r      <= 9'h000;
         hold_full_r <= 1'b0;
      end else if (wr_hold) begin
         hold_r      <= {tx_ninth_bit, dat_i[7:0]}; // RL4 RL5
         hold_full_r <= 1'b1;
      end else if (tx_load) begin
         hold_full_r <= 1'b0;
      end
   end

   // Frame shifter: start, data LSB first, stop
   always_ff @(posedge clk_i) begin
      if (rst_i || !tx_on) begin
         tx_shift_reg <= 11'h7FF;
         tx_bits_r    <= 4'h0;
         tx_cnt_r     <= 4'h0;
         tx_busy_r    <= 1'b0;
      end else if (tx_load) begin
         tx_shift_reg <= {1'b1, nine_bit_tx_select ? hold_r[8] : 1'b1, hold_r[7:0], 1'b0}; // RL19
         tx_bits_r    <= nine_bit_tx_select ? uart_pkg::TX_BITS_9 : uart_pkg::TX_BITS_8; // RL4
         tx_cnt_r     <= 4'h0;
         tx_busy_r    <= 1'b1;
      end else if (tx_busy_r && tick_r) begin
         tx_cnt_r <= tx_cnt_r + 4'h1;
         if (tx_step) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_bits_r    <= tx_bits_r - 4'h1;
            tx_busy_r    <= !tx_done;
         end
      end
   end

   // Pin driver with polarity control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pin_r <= 1'b1;
      end else begin
         tx_pin_r <= (tx_busy_r ? tx_shift_reg[0] : 1'b1) ^ tx_invert; // RL6
      end
   end
   assign tx_clock_pin_o = tx_pin_r;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Receiver
   uart_pkg::rx_state_t rx_state_r;
   uart_pkg::rx_char_t  push_char;
   uart_pkg::rx_char_t  head;
   logic [8:0]          rx_shift_reg;
   logic [3:0]          rx_cnt_r;
   logic [3:0]          rx_bit_r;
   logic [1:0]          samp_r;
   logic                rx_prev_r;
   logic                overrun_error_flag_r;
   logic [1:0]          fifo_count;
   wire rx_line   = rx_data_pin_i ^ rx_invert; // RL17
   wire rx_on     = continuous_receive_enable && !sync_mode && port_enable; // RL7
   wire decide    = tick_r && (rx_cnt_r == uart_pkg::MAJ_DECIDE);
   wire maj       = (samp_r[1] & samp_r[0]) | (samp_r[1] & rx_line) | (samp_r[0] & rx_line); // RL11
   wire last_bit  = rx_bit_r == (nine_bit_rx_select ? 4'h8 : 4'h7);
   wire rx_end    = rx_on && (rx_state_r == uart_pkg::RX_STOP) && decide;
   wire filtered  = address_detect_enable && nine_bit_rx_select && !push_char.ninth;
   wire fifo_full = fifo_count == uart_pkg::FIFO_DEPTH; // RL14
   wire push      = rx_end && !filtered && !fifo_full; // RL13
   wire rx_available_flag = rx_on && (fifo_count != 2'h0);
   wire rx_idle   = rx_state_r == uart_pkg::RX_IDLE;

   // Assembled character, aligned by length
   assign push_char.framing_error_flag  = !maj; // RL12
   assign push_char.ninth = nine_bit_rx_select && rx_shift_reg[8];
   assign push_char.data  = nine_bit_rx_select ? rx_shift_reg[7:0] : rx_shift_reg[8:1];

   // Recovery state machine at 16x
   always_ff @(posedge clk_i) begin
      if (rst_i || !rx_on) begin
         rx_state_r <= uart_pkg::RX_IDLE; // RL7
         rx_cnt_r   <= 4'h0;
      end else if (tick_r) begin
         rx_cnt_r <= rx_cnt_r + 4'h1; // RL8
         case (rx_state_r)
            uart_pkg::RX_IDLE: begin
               rx_cnt_r <= 4'h0;
               if (rx_prev_r && !rx_line && !overrun_error_flag_r) rx_state_r <= uart_pkg::RX_START; // RL9 RL16
            end
            uart_pkg::RX_START: begin
               if (decide) rx_state_r <= maj ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA; // RL9 RL10
            end
            uart_pkg::RX_DATA: begin
               if (decide && last_bit) rx_state_r <= uart_pkg::RX_STOP;
            end
            uart_pkg::RX_STOP: begin
               if (decide) rx_state_r <= uart_pkg::RX_IDLE;
            end
            default: rx_state_r <= uart_pkg::RX_IDLE;
         endcase
      end
   end

   // Line history, majority samples and bit shifter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_prev_r    <= 1'b1;
         samp_r       <= 2'h0;
         rx_shift_reg <= 9'h000;
         rx_bit_r     <= 4'h0;
      end else if (tick_r) begin
         rx_prev_r <= rx_line;
         if (rx_cnt_r == uart_pkg::MAJ_FIRST || rx_cnt_r == uart_pkg::MAJ_SECOND) begin
            samp_r <= {samp_r[0], rx_line}; // RL11
         end
         if (rx_state_r == uart_pkg::RX_START) rx_bit_r <= 4'h0;
         if (decide && rx_state_r == uart_pkg::RX_DATA) begin
            rx_shift_reg <= {maj, rx_shift_reg[8:1]}; // RL8 RL11 RL19
            rx_bit_r     <= rx_bit_r + 4'h1;
         end
      end
   end

   // Overrun: set by a third character, cleared by either enable
   always_ff @(posedge clk_i) begin
      if (rst_i || !rx_on) begin
         overrun_error_flag_r <= 1'b0; // RL22
      end else if (rx_end && !filtered && fifo_full) begin
         overrun_error_flag_r <= 1'b1; // RL16
      end
   end

   // Two-entry receive FIFO, flushed when the port is off
   rx_fifo u_fifo (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (!port_enable),
      .push_i  (push),
      .data_i  (push_char),
      .pop_i   (rd_data), // RL15
      .head_o  (head),
      .count_o (fifo_count)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read mux, status and interrupt
   wire       have = fifo_count != 2'h0;
   wire [7:0] txc_rd = tx_ctrl_r | ({7'h00, tx_shifter_empty} << uart_pkg::TXC_SHIFT_EMPTY);
   wire [7:0] rxc_rd = rx_ctrl_r
                     | ({7'h00, have && head.framing_error_flag} << uart_pkg::RXC_FRAME_ERR)
                     | ({7'h00, overrun_error_flag_r} << uart_pkg::RXC_OVERRUN)
                     | ({7'h00, have && head.ninth} << uart_pkg::RXC_D9);
   wire [7:0] bc_rd  = baud_ctrl_r | ({7'h00, rx_idle} << uart_pkg::BC_IDLE);
   wire [7:0] ic_rd  = irq_ctrl_r
                     | ({7'h00, tx_buffer_empty_flag} << uart_pkg::IC_TXIF)
                     | ({7'h00, rx_available_flag} << uart_pkg::IC_RCIF);

   // Register selection; unmapped offsets read zero
   always_comb begin
      case (adr_i)
         uart_pkg::OFS_TX_CTRL:   rd_nxt = txc_rd; // RL18
         uart_pkg::OFS_RX_CTRL:   rd_nxt = rxc_rd;
         uart_pkg::OFS_BAUD_CTRL: rd_nxt = bc_rd;
         uart_pkg::OFS_DIV_LO:    rd_nxt = div_lo_r;
         uart_pkg::OFS_DIV_HI:    rd_nxt = div_hi_r;
         uart_pkg::OFS_TX_HOLD:   rd_nxt = hold_r[7:0];
         uart_pkg::OFS_RX_DATA:   rd_nxt = have ? head.data : 8'h00; // RL15
         uart_pkg::OFS_IRQ_CTRL:  rd_nxt = ic_rd;
         default:                 rd_nxt = 8'h00;
      endcase
   end

   // One wait state answer, data registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (rd) dat_o <= {24'h000000, rd_nxt};
      end
   end
   assign ack_o = ack_r;

   // Interrupt gated by peripheral and global enables
   wire irq_gate = irq_ctrl_r[uart_pkg::IC_PERIPH_EN] && irq_ctrl_r[uart_pkg::IC_GLOBAL_EN];
   assign irq_o = irq_gate && ((irq_ctrl_r[uart_pkg::IC_TXIE] && tx_buffer_empty_flag)
                             || (irq_ctrl_r[uart_pkg::IC_RCIE] && rx_available_flag)); // RL3

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_load_then_idle;
      tx_load ##1 (tx_busy_r && !hold_full_r);
   endsequence

   a_txif_enable: assert property ($rose(tx_enable) && !hold_full_r |-> tx_buffer_empty_flag) // RL2
      else $error("empty flag not raised on enable");
   a_txif_clear: assert property (!tx_buffer_empty_flag && tx_enable |-> hold_full_r && tx_busy_r) // RL21
      else $error("empty flag clear without queued character");
   a_irq_now: assert property (irq_gate && irq_ctrl_r[uart_pkg::IC_TXIE] && tx_buffer_empty_flag
                               |-> irq_o) // RL3
      else $error("transmit interrupt not asserted");
   a_start_low: assert property (s_load_then_idle ##0 $stable(tx_invert)
                                 |=> tx_clock_pin_o == tx_invert) // RL19 RL6
      else $error("start bit level wrong");
   a_queue_load: assert property (tx_done && hold_full_r && tx_on |=> tx_load ##1 tx_busy_r) // RL20
      else $error("queued character not loaded after stop");
   a_rx_gate: assert property (!rx_on |=> rx_idle) // RL7
      else $error("receiver active while disabled");
   a_abort_start: assert property (rx_state_r == uart_pkg::RX_START && decide && maj
                                   |=> rx_idle && !overrun_error_flag_r && $stable(fifo_count)) // RL10
      else $error("false start not abandoned quietly");
   a_fifo_depth: assert property (fifo_count <= uart_pkg::FIFO_DEPTH) // RL14
      else $error("receive FIFO above two");
   a_push_flag: assert property (push && rx_on |=> rx_available_flag) // RL13
      else $error("available flag not set after push");
   a_ovr_block: assert property (overrun_error_flag_r |-> rx_idle && !push) // RL16
      else $error("character accepted during overrun");
   a_ovr_clear: assert property (overrun_error_flag_r && !rx_on |=> !overrun_error_flag_r) // RL22
      else $error("overrun not cleared by enable");
   a_unused_zero: assert property (ack_r && $past(rd) && $past(adr_i) == uart_pkg::OFS_TX_CTRL
                                   |-> dat_o[7] == 1'b0 && dat_o[3] == 1'b0) // RL18
      else $error("unimplemented bit read as one");
endmodule

// ---- serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT = 16
) (
   // Clock
   input  wire logic clk_i,
   // Line side
   input  wire logic tx_line_i,
   output logic      rx_line_o,
   // Control and captured frame
   input  wire logic listen_i,
   input  wire logic nine_i,
   input  wire logic inv_i,
   output logic [9:0] got_o,
   output logic      got_v_o
);
   logic       raw = 1'b1;
   logic [9:0] v;
   int         k;
   // Line idles high from raw held at one, optionally inverted
   assign rx_line_o = raw ^ inv_i;
   // Sends start low, data LSB first, then the chosen stop level
   task automatic send(input logic [8:0] d, input logic nine, input logic stop);
      int i;
      @(posedge clk_i);
      raw <= 1'b0;
      repeat (BIT) @(posedge clk_i);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
         raw <= d[i];
         repeat (BIT) @(posedge clk_i);
      end
      raw <= stop;
      repeat (BIT) @(posedge clk_i);
      raw <= 1'b1;
      repeat (BIT) @(posedge clk_i);
   endtask
   // Low pulse shorter than half a bit
   task automatic glitch(input int n);
      @(posedge clk_i);
      raw <= 1'b0;
      repeat (n) @(posedge clk_i);
      raw <= 1'b1;
      repeat (2 * BIT) @(posedge clk_i);
   endtask
   // Decodes transmitted frames at bit centres, stop level in bit 9
   always begin
      @(negedge tx_line_i);
      repeat (BIT / 2) @(posedge clk_i);
      if (listen_i && tx_line_i === 1'b0) begin
         v = 10'h000;
         for (k = 0; k < (nine_i ? 9 : 8); k++) begin
            repeat (BIT) @(posedge clk_i);
            v[k] = tx_line_i;
         end
         repeat (BIT) @(posedge clk_i);
         v[9] = tx_line_i;
         got_o <= v;
         got_v_o <= 1'b1;
         @(posedge clk_i);
         got_v_o <= 1'b0;
      end
   end
endmodule

// ---- async_serial_tx_rx_tb_top.sv ----
`timescale 1ns/1ps
module async_serial_tx_rx_tb_top;
   // Zero divisor, high speed: one tick per clock, sixteen clocks a bit
   localparam int BIT = 16;
   localparam logic [7:0] TXC = uart_pkg::OFS_TX_CTRL;
   localparam logic [7:0] RXC = uart_pkg::OFS_RX_CTRL;
   localparam logic [7:0] BC = uart_pkg::OFS_BAUD_CTRL;
   localparam logic [7:0] IC = uart_pkg::OFS_IRQ_CTRL;
   localparam logic [7:0] THR = uart_pkg::OFS_TX_HOLD;
   localparam logic [7:0] RDR = uart_pkg::OFS_RX_DATA;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o, irq_o, rx_line, tx_line, got_v;
   logic        listen = 1'b1;
   logic        nine = 1'b0;
   logic        inv = 1'b0;
   logic [9:0]  got, e10;
   logic [15:0] ent;
   logic [15:0] rd_q[$];
   logic [9:0]  tx_q[$];
   logic [7:0]  b0, b1, b2, ov[4];
   int          n_fail = 0;
   int          compares = 0;
   int          cyc_cnt = 0;
   int          seed = 95;
   always #2.5 clk_i = ~clk_i;
   async_serial_tx_rx DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .rx_data_pin_i(rx_line), .tx_clock_pin_o(tx_line), .irq_o(irq_o));
   serial_peer #(.BIT(BIT)) peer (.clk_i(clk_i), .tx_line_i(tx_line), .rx_line_o(rx_line),
      .listen_i(listen), .nine_i(nine), .inv_i(inv), .got_o(got), .got_v_o(got_v));
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      rd_q.push_back({m, e});
      bus(1'b0, a, 8'h00);
   endtask
   task automatic wait_tx();
      for (int i = 0; i < 2000 && tx_q.size() != 0; i++) @(posedge clk_i);
      repeat (3 * BIT) @(posedge clk_i);
      chk("tx frames left", 32'h0, tx_q.size());
   endtask
   // Watches read answers and decoded frames against the oldest notes
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) begin
         ent = rd_q.pop_front();
         chk("read data", {24'h0, ent[7:0] & ent[15:8]}, dat_o & {24'hFFFFFF, ent[15:8]});
      end
      if (got_v === 1'b1) begin
         e10 = (tx_q.size() > 0) ? tx_q.pop_front() : 10'h3FF;
         chk("tx frame", {22'h0, e10}, {22'h0, got});
      end
   end
   // Cuts a hang short
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 30000) begin
         n_fail++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(RXC, 8'h00);
      rd(BC, 8'h00, 8'hBF);
      rd(IC, 8'h00);
      rd(8'h20, 8'h00);
      wr(TXC, 8'hFF);
      rd(TXC, 8'h75, 8'hFD);
      wr(BC, 8'hFF);
      rd(BC, 8'h38, 8'hBF);
      wr(BC, 8'h00);
      wr(TXC, 8'h00);
      wr(uart_pkg::OFS_DIV_LO, 8'h00);
      wr(uart_pkg::OFS_DIV_HI, 8'h00);
      wr(RXC, 8'h90);
      wr(TXC, 8'h24);
      rd(IC, 8'h10, 8'h30);
      wr(IC, 8'h0D);
      chk("irq on", 32'h1, {31'h0, irq_o});
      wr(IC, 8'h0C);
      chk("irq off", 32'h0, {31'h0, irq_o});
      $display("test registers done");
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      tx_q.push_back({2'b10, b0});
      tx_q.push_back({2'b10, b1});
      wr(THR, b0);
      wr(THR, b1);
      rd(IC, 8'h00, 8'h10);
      rd(TXC, 8'h24);
      wait_tx();
      rd(TXC, 8'h26);
      nine <= 1'b1;
      wr(TXC, 8'h65);
      b2 = 8'($random(seed));
      tx_q.push_back({2'b11, b2});
      wr(THR, b2);
      wait_tx();
      nine <= 1'b0;
      wr(TXC, 8'h24);
      $display("test transmit done");
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      peer.send({1'b0, b0}, 1'b0, 1'b1);
      peer.send({1'b0, b1}, 1'b0, 1'b1);
      rd(IC, 8'h20, 8'h20);
      rd(RDR, b0);
      rd(RDR, b1);
      rd(RDR, 8'h00);
      peer.send(9'h0F0, 1'b0, 1'b0);
      rd(RXC, 8'h94);
      rd(RDR, 8'hF0);
      peer.glitch(4);
      peer.send(9'h081, 1'b0, 1'b1);
      rd(RXC, 8'h90, 8'hFB);
      rd(RDR, 8'h81);
      rd(RDR, 8'h00);
      wr(RXC, 8'hD8);
      peer.send(9'h1C3, 1'b1, 1'b1);
      peer.send(9'h05A, 1'b1, 1'b1);
      rd(RXC, 8'hD9);
      rd(RDR, 8'hC3);
      rd(RDR, 8'h00);
      wr(RXC, 8'h90);
      $display("test receive done");
      for (int i = 0; i < 4; i++) begin
         ov[i] = 8'($random(seed));
         peer.send({1'b0, ov[i]}, 1'b0, 1'b1);
      end
      rd(RXC, 8'h92, 8'hFB);
      rd(RDR, ov[0]);
      rd(RDR, ov[1]);
      rd(RDR, 8'h00);
      wr(RXC, 8'h80);
      rd(RXC, 8'h80, 8'hFB);
      peer.send(9'h055, 1'b0, 1'b1);
      wr(RXC, 8'h90);
      rd(RDR, 8'h00);
      wr(BC, 8'h20);
      inv <= 1'b1;
      repeat (2 * BIT) @(posedge clk_i);
      peer.send(9'h03A, 1'b0, 1'b1);
      rd(RDR, 8'h3A);
      inv <= 1'b0;
      wr(BC, 8'h00);
      listen <= 1'b0;
      wr(BC, 8'h10);
      repeat (2) @(posedge clk_i);
      chk("tx idle", 32'h0, {31'h0, tx_line});
      $display("test errors and polarity done");
      report_and_stop();
   end
endmodule
